// ---- rtl/hcw_top.v ----
// two-wire register bank, waveform memory and playback sequencer
`timescale 1ns/1ps
`include "hcw_defs.vh"

module hcw_top
#(
	parameter [6:0]  DEV_ADDR = 7'h2A,          // bus address, value arbitrary
	parameter        RAW_DIV  = `HCW_RAW_RATE_HZ // clocks per raw sample
)
(
	input  wire       clk,          // 125 MHz clock
	input  wire       srst,         // synchronous reset, active high
	input  wire       scl,          // bus clock pin
	input  wire       sda_i,        // bus data pin level
	output wire       sda_o,        // bus data drive value
	output reg        sda_oe,       // bus data drive enable
	output reg        standby_q,    // low-power standby
	output reg        analog_sel_q, // analog input path chosen
	output reg  [1:0] gain_q,       // output gain code
	output reg  [1:0] timeout_q,    // fifo timeout select
	output reg        amp_on_q,     // boost and amplifier enable
	output reg        data_ready_q, // digital path accepts data
	output reg        busy_q,       // sequencer playing
	output reg  [7:0] wave_q,       // signed output sample
	output reg  [7:0] env_q         // envelope byte of segment
);

	// ==============================
	// state codes
	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_SLOT = 3'h1;
	localparam [2:0] S_HDR  = 3'h2;
	localparam [2:0] S_SEG  = 3'h3;
	localparam [2:0] S_PLAY = 3'h4;
	localparam [2:0] S_RAW  = 3'h5;
	localparam [2:0] S_NEXT = 3'h6;
	localparam [63:0] STEP64 = (`HCW_PHASE_ONE * `HCW_FSTEP_UHZ) /
		(`HCW_CLK_HZ * `HCW_UHZ_PER_HZ);
	localparam [31:0] PH_STEP = STEP64[31:0];
	localparam [31:0] RAW_TOP = RAW_DIV - 1;
	localparam [7:0]  CTRL_RST = `HCW_CTRL_RST;

	// ==============================
	// storage
	reg  [7:0]  mem [0:`HCW_MEM_DEPTH-1];
	reg  [7:0]  slot_q [0:7];
	reg  [7:0]  page_q;
	reg         ovr_q;
	reg         go_q;
	reg  [2:0]  bus_q;
	reg  [3:0]  bit_q;
	reg  [7:0]  sh_q;
	reg  [7:0]  tx_q;
	reg  [7:0]  ptr_q;
	reg         nack_q;
	reg         scl_q;
	reg         sda_q;
	reg  [2:0]  st_q;
	reg  [3:0]  sidx_q;
	reg  [2:0]  fcnt_q;
	reg  [10:0] addr_q;
	reg  [15:0] start_q;
	reg  [15:0] stop_q;
	reg  [7:0]  rep_q;
	reg  [7:0]  amp_q;
	reg  [7:0]  freq_q;
	reg  [7:0]  dur_q;
	reg  [7:0]  cyc_q;
	reg  [31:0] ph_q;
	reg  [31:0] div_q;
	reg  [7:0]  rd_data;
	integer     i;

	// ==============================
	// functions
	// memory index from a page number and offset, page 1 is index 0
	function [10:0] hcw_page_idx;
		input [7:0] page;
		input [7:0] off;
		reg   [7:0] pm;
		begin
			pm = page - 8'h01;
			hcw_page_idx = {pm[2:0], off};
		end
	endfunction

	// memory index from a 16-bit header address, mode bit stripped
	function [10:0] hcw_hdr_idx;
		input [15:0] a;
		begin
			hcw_hdr_idx = {a[10:8], a[7:0]};
		end
	endfunction

	// ==============================
	// bus edge detect, pins are synchronous
	wire scl_rise = scl & ~scl_q;
	wire scl_fall = ~scl & scl_q;
	wire bus_start = scl & scl_q & sda_q & ~sda_i;
	wire bus_stop  = scl & scl_q & ~sda_q & sda_i;
	wire mem_page  = (page_q != `HCW_PAGE_CTRL) && (page_q <= `HCW_PAGE_LAST);
	wire wr_byte   = scl_fall && (bit_q == `HCW_BIT_LAST) && (bus_q == `HCW_BUS_WR);
	wire [7:0] slot_off = ptr_q - `HCW_REG_SLOT0;
	wire is_slot   = (ptr_q >= `HCW_REG_SLOT0) &&
		(ptr_q < `HCW_REG_SLOT0 + {4'h0, `HCW_NUM_SLOTS});
	wire done_cyc;

	assign sda_o = 1'b0; // open drain: only pull low

	// read data for the current pointer, unmapped reads as zero
	always @*
	begin
		rd_data = 8'h00;
		if (ptr_q == `HCW_REG_PAGE)
			rd_data = page_q;
		else if (mem_page)
			rd_data = mem[hcw_page_idx(page_q, ptr_q)];
		else if (page_q == `HCW_PAGE_CTRL)
		begin
			if (ptr_q == `HCW_REG_GAIN)
				rd_data = {5'h00, analog_sel_q, gain_q};
			else if (ptr_q == `HCW_REG_CTRL)
				rd_data = {1'b0, standby_q, 2'h0, timeout_q, ovr_q, go_q};
			else if (is_slot)
				rd_data = slot_q[slot_off[2:0]];
		end
	end

	// ==============================
	// two-wire slave: address, pointer, data bytes with auto increment
	always @(posedge clk)
	begin
		if (srst)
		begin
			scl_q  <= 1'b1;
			sda_q  <= 1'b1;
			bus_q  <= `HCW_BUS_IDLE;
			bit_q  <= 4'h0;
			sh_q   <= 8'h00;
			tx_q   <= 8'h00;
			ptr_q  <= 8'h00;
			nack_q <= 1'b0;
			sda_oe <= 1'b0;
		end
		else
		begin
			scl_q <= scl;
			sda_q <= sda_i;
			// the clock fall that follows a start carries no bit, so count from one below zero
			if (bus_start)
			begin
				bus_q  <= `HCW_BUS_DEV;
				bit_q  <= `HCW_BIT_PRE;
				sda_oe <= 1'b0;
			end
			else if (bus_stop)
			begin
				bus_q  <= `HCW_BUS_IDLE;
				sda_oe <= 1'b0;
			end
			else if (bus_q != `HCW_BUS_IDLE)
			begin
				if (scl_rise)
				begin
					if (bit_q == `HCW_BIT_ACK)
						nack_q <= sda_i; // master ack on reads
					else
						sh_q <= {sh_q[6:0], sda_i};
				end
				else if (scl_fall)
				begin
					if (bit_q == `HCW_BIT_LAST)
					begin
						bit_q  <= `HCW_BIT_ACK;
						sda_oe <= 1'b0;
						case (bus_q)
							`HCW_BUS_DEV:
							begin
								if (sh_q[7:1] == DEV_ADDR)
								begin
									sda_oe <= 1'b1;
									bus_q  <= sh_q[0] ? `HCW_BUS_RD : `HCW_BUS_PTR;
								end
								else
									bus_q <= `HCW_BUS_IDLE;
							end
							`HCW_BUS_PTR:
							begin
								ptr_q  <= sh_q;
								sda_oe <= 1'b1;
								bus_q  <= `HCW_BUS_WR;
							end
							`HCW_BUS_WR:
							begin
								ptr_q  <= ptr_q + 8'h01;
								sda_oe <= 1'b1;
							end
							`HCW_BUS_RD:
								ptr_q <= ptr_q + 8'h01;
							default:
								bus_q <= `HCW_BUS_IDLE;
						endcase
					end
					else if (bit_q == `HCW_BIT_ACK)
					begin
						bit_q  <= 4'h0;
						sda_oe <= 1'b0;
						if (bus_q == `HCW_BUS_RD)
						begin
							if (nack_q)
								bus_q <= `HCW_BUS_IDLE;
							else
							begin
								tx_q   <= rd_data;
								sda_oe <= ~rd_data[7];
							end
						end
					end
					else
					begin
						bit_q <= bit_q + 4'h1;
						if (bus_q == `HCW_BUS_RD)
						begin
							tx_q   <= {tx_q[6:0], 1'b0};
							sda_oe <= ~tx_q[6];
						end
					end
				end
			end
		end
	end

	// ==============================
	// waveform memory write from the bus, page and offset form the index
	always @(posedge clk)
	begin
		if (wr_byte && mem_page && ptr_q != `HCW_REG_PAGE)
			mem[hcw_page_idx(page_q, ptr_q)] <= sh_q;
	end

	// ==============================
	// control registers; a bus write of the trigger wins over its clear
	always @(posedge clk)
	begin
		if (srst)
		begin
			page_q       <= `HCW_PAGE_CTRL;
			standby_q    <= CTRL_RST[`HCW_BIT_STANDBY];
			analog_sel_q <= 1'b0;
			gain_q       <= 2'h0;
			timeout_q    <= 2'h0;
			ovr_q        <= 1'b0;
			go_q         <= 1'b0;
			for (i = 0; i < 8; i = i + 1)
				slot_q[i] <= 8'h00;
		end
		else
		begin
			if (st_q == S_SLOT && (sidx_q == `HCW_NUM_SLOTS ||
				slot_q[sidx_q[2:0]] == 8'h00))
				go_q <= 1'b0;
			if (wr_byte)
			begin
				if (ptr_q == `HCW_REG_PAGE)
					page_q <= sh_q;
				else if (page_q == `HCW_PAGE_CTRL)
				begin
					if (ptr_q == `HCW_REG_GAIN)
					begin
						analog_sel_q <= sh_q[`HCW_BIT_IFSEL];
						gain_q       <= sh_q[1:0];
					end
					else if (ptr_q == `HCW_REG_CTRL)
					begin
						standby_q <= sh_q[`HCW_BIT_STANDBY];
						timeout_q <= sh_q[3:2];
						ovr_q     <= sh_q[`HCW_BIT_OVERRIDE];
						go_q      <= sh_q[`HCW_BIT_GO];
					end
					else if (is_slot)
						slot_q[slot_off[2:0]] <= sh_q;
				end
			end
		end
	end

	// ==============================
	// status outputs steered by the control bits and the sequencer state
	always @(posedge clk)
	begin
		if (srst)
		begin
			amp_on_q     <= 1'b0;
			data_ready_q <= 1'b0;
			busy_q       <= 1'b0;
		end
		else
		begin
			amp_on_q     <= ovr_q | (st_q != S_IDLE);
			data_ready_q <= ~standby_q & ~analog_sel_q;
			busy_q       <= (st_q != S_IDLE);
		end
	end

	// ==============================
	// sequencer: slot, header fetch, segment fetch, play
	wire [31:0] ph_inc = PH_STEP * {24'h000000, freq_q};
	wire [32:0] ph_sum = {1'b0, ph_q} + {1'b0, ph_inc};
	assign done_cyc = ph_sum[32] && (cyc_q + 8'h01 >= dur_q);
	wire [7:0]  cur_id = slot_q[sidx_q[2:0]];
	wire [10:0] hdr_base = {cur_id[7:0], 2'h0} + {3'h0, cur_id} - `HCW_HDR_BIAS;
	wire [10:0] stop_idx = hcw_hdr_idx(stop_q);

	always @(posedge clk)
	begin
		if (srst)
		begin
			st_q    <= S_IDLE;
			sidx_q  <= 4'h0;
			fcnt_q  <= 3'h0;
			addr_q  <= 11'h000;
			start_q <= 16'h0000;
			stop_q  <= 16'h0000;
			rep_q   <= 8'h00;
			amp_q   <= 8'h00;
			freq_q  <= 8'h00;
			dur_q   <= 8'h00;
			env_q   <= 8'h00;
			cyc_q   <= 8'h00;
			ph_q    <= 32'h00000000;
			div_q   <= 32'h00000000;
		end
		else
		begin
			case (st_q)
				S_IDLE:
				begin
					sidx_q <= 4'h0;
					if (go_q && !standby_q)
						st_q <= S_SLOT;
				end
				S_SLOT:
				begin
					if (sidx_q == `HCW_NUM_SLOTS || cur_id == 8'h00)
						st_q <= S_IDLE;
					else
					begin
						addr_q <= hdr_base;
						fcnt_q <= 3'h0;
						st_q   <= S_HDR;
					end
				end
				S_HDR:
				begin
					addr_q <= addr_q + 11'h001;
					fcnt_q <= fcnt_q + 3'h1;
					case (fcnt_q)
						3'h0: start_q[15:8] <= mem[addr_q];
						3'h1: start_q[7:0]  <= mem[addr_q];
						3'h2: stop_q[15:8]  <= mem[addr_q];
						3'h3: stop_q[7:0]   <= mem[addr_q];
						default: rep_q      <= mem[addr_q];
					endcase
					if (fcnt_q == `HCW_HDR_LEN - 3'h1)
					begin
						addr_q <= hcw_hdr_idx(start_q);
						fcnt_q <= 3'h0;
						div_q  <= 32'h00000000;
						st_q   <= start_q[15] ? S_SEG : S_RAW;
					end
				end
				S_SEG:
				begin
					addr_q <= addr_q + 11'h001;
					fcnt_q <= fcnt_q + 3'h1;
					case (fcnt_q[1:0])
						2'h0: amp_q   <= mem[addr_q];
						2'h1: freq_q  <= mem[addr_q];
						2'h2: dur_q   <= mem[addr_q];
						default: env_q <= mem[addr_q];
					endcase
					if (fcnt_q[1:0] == `HCW_SEG_LEN)
					begin
						ph_q  <= 32'h00000000;
						cyc_q <= 8'h00;
						st_q  <= S_PLAY;
					end
				end
				S_PLAY:
				begin
					ph_q <= ph_sum[31:0];
					if (ph_sum[32])
						cyc_q <= cyc_q + 8'h01;
					if (done_cyc || dur_q == 8'h00)
					begin
						fcnt_q <= 3'h0;
						st_q   <= (addr_q > stop_idx) ? S_NEXT : S_SEG;
					end
				end
				S_RAW:
				begin
					div_q <= div_q + 32'h00000001;
					if (div_q == RAW_TOP)
					begin
						div_q  <= 32'h00000000;
						addr_q <= addr_q + 11'h001;
						if (addr_q >= stop_idx)
							st_q <= S_NEXT;
					end
				end
				S_NEXT:
				begin
					// repeat count 0x01 plays once; zero also plays once
					if (rep_q > 8'h01)
					begin
						rep_q  <= rep_q - 8'h01;
						addr_q <= hcw_hdr_idx(start_q);
						st_q   <= start_q[15] ? S_SEG : S_RAW;
					end
					else
					begin
						sidx_q <= sidx_q + 4'h1;
						st_q   <= S_SLOT;
					end
				end
				default:
					st_q <= S_IDLE;
			endcase
		end
	end

	// ==============================
	// sine sample: parabola per half cycle scaled by amplitude
	wire [7:0]  ph_x  = ph_q[30:23];
	wire [15:0] par   = {8'h00, ph_x} * {8'h00, 8'hFF - ph_x};
	wire [15:0] scl_p = {8'h00, par[13:6]} * {8'h00, amp_q};
	wire [6:0]  mag   = scl_p[15:9];

	always @(posedge clk)
	begin
		if (srst)
			wave_q <= 8'h00;
		else if (st_q == S_PLAY)
			wave_q <= ph_q[31] ? (8'h00 - {1'b0, mag}) : {1'b0, mag};
		else if (st_q == S_RAW)
			wave_q <= mem[addr_q];
		else if (st_q == S_IDLE)
			wave_q <= 8'h00;
	end

endmodule

// ---- rtl/hcw_defs.vh ----
// constants for the haptic control and wave header block
// How it works
// - control bit 6 at 0x02 is standby; host clears it first
// - bit 2 of 0x01 picks analog input or digital waveform path
// - bits 1:0 of 0x01 hold gain code, 0 lowest, 3 highest
// - bits 3:2 of 0x02 select the fifo timeout period
// - bit 1 of 0x02 forces boost and amplifier on for analog use
// - digital path accepts data once out of standby with bit 2 of 0x01 clear
// - writing 0x01 to 0x02 sets trigger; sequencer plays listed ids
// - page register 0xFF: zero maps control space, 0x01 to 0x08 map memory
// - slots from 0x03 hold ids played in order; zero id ends
// - playback stops after eight slots even without a zero id
// - five-byte header entry: start hi, lo, stop hi, lo, repeat
// - start high bit 7 marks synthesis; low bits give page part
// - synthesis segments: amplitude, frequency, duration cycles, envelope
// - frequency code steps about 7.8 Hz; 0x19 gives about 195 Hz
// - amplitude 0xFF is full scale; envelope 0x00 means no ramps
`ifndef HCW_DEFS_VH
`define HCW_DEFS_VH

// ==============================
// register offsets and fields
`define HCW_REG_GAIN      8'h01
`define HCW_REG_CTRL      8'h02
`define HCW_REG_SLOT0     8'h03
`define HCW_REG_PAGE      8'hFF
`define HCW_NUM_SLOTS     4'h8
`define HCW_BIT_IFSEL     2
`define HCW_BIT_STANDBY   6
`define HCW_BIT_OVERRIDE  1
`define HCW_BIT_GO        0
`define HCW_CTRL_MASK     8'h4F
`define HCW_GAIN_MASK     8'h07
`define HCW_CTRL_RST      8'h40
`define HCW_PAGE_CTRL     8'h00
`define HCW_PAGE_LAST     8'h08
`define HCW_SYNTH_BIT     7
`define HCW_HDR_LEN       3'h5
`define HCW_HDR_BIAS      11'h004
`define HCW_SEG_LEN       2'h3
`define HCW_MEM_DEPTH     2048

// ==============================
// timing and synthesis
`define HCW_CLK_HZ        64'd125000000
`define HCW_FSTEP_UHZ     64'd7812500
`define HCW_UHZ_PER_HZ    64'd1000000
`define HCW_PHASE_ONE     64'd4294967296
`define HCW_RAW_RATE_HZ   15625

// ==============================
// bus states
`define HCW_BUS_IDLE      3'h0
`define HCW_BUS_DEV       3'h1
`define HCW_BUS_PTR       3'h2
`define HCW_BUS_WR        3'h3
`define HCW_BUS_RD        3'h4
`define HCW_BIT_LAST      4'h7
`define HCW_BIT_ACK       4'h8
`define HCW_BIT_PRE       4'hF

`endif

// ---- sim/hcw_asserts.sv ----
// concurrent checks on the haptic control block ports
`timescale 1ns/1ps
module hcw_asserts
(
	input wire logic       clk,          // block clock
	input wire logic       srst,         // sync reset
	input wire logic       scl,          // bus clock level
	input wire logic       sda_oe,       // data pull-low enable
	input wire logic       standby_q,    // standby state
	input wire logic       analog_sel_q, // analog path chosen
	input wire logic [1:0] gain_q,       // gain code
	input wire logic [1:0] timeout_q,    // timeout select
	input wire logic       amp_on_q,     // amplifier on
	input wire logic       data_ready_q, // digital path ready
	input wire logic       busy_q,       // sequencer busy
	input wire logic [7:0] wave_q        // output sample
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// ==============================
	// sequences
	// sequencer idle for two cycles
	sequence idle2_s;
		!busy_q ##1 !busy_q;
	endsequence
	// playback start seen at the ports
	sequence start_s;
		$rose(busy_q);
	endsequence
	// ==============================
	// properties
	standby_rst_a: assert property (disable iff (1'b0) srst |=> standby_q && !busy_q)
		else $error("standby not set by reset");
	ready_follow_a: assert property (data_ready_q == $past(!standby_q && !analog_sel_q))
		else $error("data ready does not follow standby and path");
	amp_busy_a: assert property (busy_q |-> amp_on_q)
		else $error("amplifier off while playing");
	go_wake_a: assert property (start_s |-> !standby_q && !scl)
		else $error("playback began outside a bus write or in standby");
	gain_write_a: assert property ($changed({analog_sel_q, gain_q}) |-> !scl)
		else $error("gain or path changed outside a bus write");
	ctrl_write_a: assert property ($changed({standby_q, timeout_q}) |-> !scl)
		else $error("standby or timeout changed outside a bus write");
	ack_edge_a: assert property ($changed(sda_oe) |-> !scl)
		else $error("data drive changed while bus clock high");
	idle_wave_a: assert property (idle2_s |-> wave_q == 8'h00)
		else $error("sample not zero while idle");
	play_c: cover property ($fell(busy_q));
endmodule

// ---- sim/hcw_host.sv ----
// host bus controller model driving the two-wire register port
`timescale 1ns/1ps
module hcw_host
#(
	parameter int PWR_WAIT = 125000, // clocks of the power-up wait
	parameter int HALF     = 4       // clocks per bus phase
)
(
	input  wire logic clk,    // block clock
	input  wire logic sda,    // resolved data line
	output logic      scl,    // bus clock, idles high
	output logic      sda_low // host pulls data low
);
	// ==============================
	// bus phases
	// bus idles released
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic power_up();
		hold(PWR_WAIT);
	endtask
	// data moves only while clock low, so no false start or stop
	task automatic bit_io(input logic d, output logic r);
		scl <= 1'b0;
		hold(HALF);
		sda_low <= ~d;
		hold(HALF);
		scl <= 1'b1;
		hold(HALF);
		r = sda;
		hold(HALF);
	endtask
	// start when stop is 0, stop when 1
	task automatic cond(input logic stop);
		scl <= 1'b0;
		hold(HALF);
		sda_low <= stop;
		hold(HALF);
		scl <= 1'b1;
		hold(HALF);
		sda_low <= ~stop;
		hold(HALF);
	endtask
	// sends b msb first, returns line bits in v and the ack bit
	task automatic byte_io(input logic [7:0] b, output logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(b[i], r);
			v[i] = r;
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic wr(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d[$],
		output logic ack);
		logic [7:0] v;
		logic       a;
		cond(1'b0);
		byte_io({dev, 1'b0}, v, ack);
		byte_io(p, v, a);
		foreach (d[i])
			byte_io(d[i], v, a);
		cond(1'b1);
	endtask
	// pointer write, repeated start, one byte read ended by nack
	task automatic rd(input logic [6:0] dev, input logic [7:0] p, output logic [7:0] v);
		logic a;
		cond(1'b0);
		byte_io({dev, 1'b0}, v, a);
		byte_io(p, v, a);
		cond(1'b0);
		byte_io({dev, 1'b1}, v, a);
		byte_io(8'hFF, v, a);
		cond(1'b1);
	endtask
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for the haptic control block
`timescale 1ns/1ps
module tb_top;
	localparam logic [6:0] DEV = 7'h2A;
	logic        clk  = 1'b0;
	logic        srst = 1'b1;
	logic        sda_low, scl, sda_oe, sda_o, standby_q, analog_sel_q, ack, last_b;
	logic        amp_on_q, data_ready_q, busy_q;
	logic [1:0]  gain_q, timeout_q;
	logic [7:0]  wave_q, env_q, rv, g, c;
	logic [7:0]  last_w = 8'h00;
	logic [31:0] seed   = 32'h6166;
	logic [7:0]  wq[$], exp_q[$];
	int          fail_count = 0, n_checks = 0, done_n = 0;
	wire         sda = ~(sda_low | (sda_oe & ~sda_o)); // pulled up when released
	always #4 clk = ~clk;
	// ==============================
	// instances
	hcw_top #(.DEV_ADDR(DEV), .RAW_DIV(4)) dut (.clk(clk), .srst(srst), .scl(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .standby_q(standby_q),
		.analog_sel_q(analog_sel_q), .gain_q(gain_q), .timeout_q(timeout_q),
		.amp_on_q(amp_on_q), .data_ready_q(data_ready_q), .busy_q(busy_q),
		.wave_q(wave_q), .env_q(env_q));
	hcw_host #(.PWR_WAIT(1250)) host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
	// ==============================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// burst write of wq starting at pointer p
	task automatic w(input logic [7:0] p);
		host.wr(DEV, p, wq, ack);
		check("ack", 8'(ack), 8'h01);
	endtask
	// trigger playback, wait for its end under a bound
	task automatic play();
		int d0;
		d0 = done_n;
		wq = {8'h01};
		w(8'h02);
		for (int i = 0; i < 3000 && done_n == d0; i++)
			@(posedge clk);
		check("played", 8'(done_n - d0), 8'h01);
		check("left", 8'(exp_q.size()), 8'h00);
	endtask
	// compares each new nonzero sample with the oldest note
	always @(posedge clk)
	begin
		last_w <= wave_q;
		last_b <= busy_q;
		if (last_b === 1'b1 && busy_q === 1'b0)
			done_n++;
		if (srst === 1'b0 && wave_q !== last_w && wave_q !== 8'h00)
		begin
			if (exp_q.size() == 0)
				check("extra", wave_q, 8'h00);
			else
				check("wave", wave_q, exp_q.pop_front());
		end
	end
	// ==============================
	// tests
	initial
	begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		host.power_up();
		host.rd(DEV, 8'h02, rv);
		check("ctrl", rv, 8'h40);
		wq = {8'h41};
		w(8'h02);
		check("busy", 8'(busy_q), 8'h00);
		check("ready", 8'(data_ready_q), 8'h00);
		wq = {8'h00};
		w(8'h02);
		check("ready", 8'(data_ready_q), 8'h01);
		$display("test wake done");
		for (int i = 0; i < 5; i++)
		begin
			seed = xs(seed);
			g = (i == 0) ? 8'h04 : seed[7:0];
			c = (i == 0) ? 8'h02 : seed[15:8] & 8'hBE;
			wq = {g, c};
			w(8'h01);
			check("gain", 8'(gain_q), 8'(g[1:0]));
			check("path", 8'(analog_sel_q), 8'(g[2]));
			check("ready", 8'(data_ready_q), 8'(!g[2]));
			check("timeout", 8'(timeout_q), 8'(c[3:2]));
			check("amp", 8'(amp_on_q), 8'(c[1]));
			host.rd(DEV, 8'h01, rv);
			check("gain reg", rv, g & 8'h07);
			host.rd(DEV, 8'h02, rv);
			check("ctrl reg", rv, c & 8'h4F);
		end
		wq = {8'h00, 8'h00};
		w(8'h01);
		$display("test config done");
		wq = {8'h5A};
		w(8'h0B);
		host.rd(DEV, 8'h0B, rv);
		check("unmapped", rv, 8'h00);
		host.wr(DEV ^ 7'h01, 8'h01, wq, ack);
		check("foreign ack", 8'(ack), 8'h00);
		$display("test refuse done");
		wq = {8'h02};
		w(8'hFF);
		wq = {8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
		w(8'h00);
		wq = {8'hFF, 8'h19, 8'h00, 8'h5C};
		w(8'h10);
		wq = {8'h01};
		w(8'hFF);
		wq = {8'h0F, 8'h01, 8'h00, 8'h01, 8'h02, 8'h02, 8'h01, 8'h03, 8'h01, 8'h04, 8'h01,
			8'h81, 8'h10, 8'h01, 8'h13, 8'h01};
		w(8'h00);
		host.rd(DEV, 8'h05, rv);
		check("mem", rv, 8'h02);
		wq = {8'h00};
		w(8'hFF);
		wq = {8'h01, 8'h02, 8'h00};
		w(8'h03);
		exp_q = {8'h11, 8'h22, 8'h33, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
		play();
		$display("test sequence done");
		wq = {8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02};
		w(8'h03);
		repeat (8) exp_q = {exp_q, 8'h44, 8'h55};
		play();
		$display("test slot limit done");
		// synthesis entry with a zero-length segment: only the envelope byte shows
		wq = {8'h03, 8'h00};
		w(8'h03);
		play();
		check("env", env_q, 8'h5C);
		$display("test synthesis done");
		results();
	end
	// cuts a hang short
	initial
	begin
		repeat (60000) @(posedge clk);
		fail_count++;
		results();
	end
endmodule
bind hcw_top hcw_asserts chk (.clk(clk), .srst(srst), .scl(scl), .sda_oe(sda_oe),
	.standby_q(standby_q), .analog_sel_q(analog_sel_q), .gain_q(gain_q),
	.timeout_q(timeout_q), .amp_on_q(amp_on_q), .data_ready_q(data_ready_q),
	.busy_q(busy_q), .wave_q(wave_q));
